/* File: rtl/mgmt_pkg.sv */
// Shared constants and carrier types for the management frame master
package mgmt_pkg;

  // Frame field widths and patterns
  localparam int          PREAMBLE_BITS = 32;
  localparam logic [1:0]  START_PAT     = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  TA_DRIVE      = 2'h2; // Write turnaround bits
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 16;
  // Header bits after preamble: st(2) op(2) phy(5) reg(5) ta(2)
  localparam int          HDR_BITS      = 16;
  localparam logic [5:0]  FRAME_BITS    = 6'h20;
  localparam logic [5:0]  TA_FIRST_BIT  = 6'h0e;
  localparam logic [5:0]  DATA_FIRST    = 6'h10;
  localparam logic [5:0]  BIT_ZERO      = 6'h00;
  localparam logic [5:0]  BIT_ONE       = 6'h01;

  // Management clock: 25 MHz system clock divided to 2.5 MHz
  localparam int          SYS_CLK_HZ    = 25000000;
  localparam int          MDC_HZ        = 2500000;
  localparam logic [3:0]  HALF_CYC      = 4'(SYS_CLK_HZ / MDC_HZ / 2);
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;

  // Request carried from the user side
  typedef struct packed {
    logic                 write;
    logic                 preamble;
    logic [ADDR_W-1:0]    phy_addr;
    logic [ADDR_W-1:0]    reg_addr;
    logic [DATA_W-1:0]    wdata;
  } mgmt_req_t;

  // Frame controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE  = 4'h2,
    ST_HDR  = 4'h4,
    ST_DATA = 4'h8
  } mgmt_state_t;

endpackage

/* File: rtl/mgmt_clk_div.sv */
// Management clock divider producing rise and fall enables
`timescale 1ns/1ns
module mgmt_clk_div
  import mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  // Outputs
  output logic      mdc,
  output logic      rise_en,
  output logic      fall_en
);

  logic [3:0] cnt_r;
  logic       mdc_r;

  // Half period counter, parked low while not running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= CNT_ZERO;
      mdc_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= CNT_ZERO;
      mdc_r <= 1'b0;
    end else if (cnt_r == HALF_CYC - CNT_ONE) begin
      cnt_r <= CNT_ZERO;
      mdc_r <= ~mdc_r;
    end else begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // Edge enables fire in the cycle the clock toggles
  assign rise_en = run && (cnt_r == HALF_CYC - CNT_ONE) && !mdc_r;
  assign fall_en = run && (cnt_r == HALF_CYC - CNT_ONE) && mdc_r;
  assign mdc     = mdc_r;

endmodule

/* File: rtl/phy_mgmt_master.sv */
// Management frame master driving the transceiver management interface
//
// Contract
// RQ1: A frame is preamble, start, op, PHY addr, reg addr, TA, data, idle.
// RQ2: An optional preamble is 32 unbroken one bits on the data line.
// RQ3: Every frame starts with the pattern 01 after the preamble.
// RQ4: The opcode is 10 for a read and 01 for a write.
// RQ5: A five-bit PHY address selects one of 32 transceivers.
// RQ6: The PHY address goes out most significant bit first.
// RQ7: A five-bit register address goes out most significant bit first.
// RQ8: A two-bit turnaround after the register address avoids a clash.
// RQ9: The data field is 16 bits, bit 15 first, in both directions.
// RQ10: Outside a frame nobody drives the data line.
// RQ11: A read releases the line from turnaround and samples 16 bits.
`timescale 1ns/1ns
module phy_mgmt_master
  import mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // User request
  input  wire logic              req_valid,
  input  wire mgmt_req_t         req,
  output logic                   req_ready,
  // User answer
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  // Management pins
  output logic                   mgmt_clock_out,
  input  wire logic              mgmt_data_line_i,
  output logic                   mgmt_data_line_o,
  output logic                   mgmt_data_line_oe
);

  mgmt_state_t          state_r;
  mgmt_req_t            req_r;
  logic [5:0]           bit_r;
  logic [HDR_BITS-1:0]  hdr_r;
  logic [DATA_W-1:0]    shift_r;
  logic [DATA_W-1:0]    rdata_r;
  logic                 done_r;
  logic                 oe_r;
  logic                 dout_r;
  logic                 din_s1_r;
  logic                 din_s2_r;
  logic                 run;
  logic                 rise_en;
  logic                 fall_en;

  // Clock divider runs only during a frame
  assign run = (state_r != ST_IDLE);

  mgmt_clk_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (run),
    .mdc     (mgmt_clock_out),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  // Two-stage synchroniser on the returned data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end else begin
      din_s1_r <= mgmt_data_line_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Ready for a new request only while idle
  assign req_ready = (state_r == ST_IDLE);

  // Frame sequencer; bits change on falling management clock edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      req_r   <= '0;
      bit_r   <= BIT_ZERO;
      hdr_r   <= '0;
      shift_r <= '0;
      oe_r    <= 1'b0;
      dout_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          oe_r   <= 1'b0; // RQ10
          dout_r <= 1'b0;
          if (req_valid) begin
            req_r   <= req;
            // RQ3 RQ4 RQ5 RQ6 RQ7 RQ8: header packed MSB first
            hdr_r   <= {START_PAT, req.write ? OP_WRITE : OP_READ,
                        req.phy_addr, req.reg_addr, TA_DRIVE};
            shift_r <= req.wdata;
            bit_r   <= BIT_ZERO;
            oe_r    <= 1'b1;
            if (req.preamble) begin
              state_r <= ST_PRE; // RQ1
              dout_r  <= 1'b1;   // RQ2
            end else begin
              state_r <= ST_HDR; // RQ1
              dout_r  <= START_PAT[1];
            end
          end
        end
        ST_PRE: begin
          if (fall_en) begin
            if (bit_r == FRAME_BITS - BIT_ONE) begin
              state_r <= ST_HDR; // RQ1
              bit_r   <= BIT_ZERO;
              dout_r  <= hdr_r[HDR_BITS-1];
            end else begin
              bit_r  <= bit_r + BIT_ONE;
              dout_r <= 1'b1; // RQ2
            end
          end
        end
        ST_HDR: begin
          if (fall_en) begin
            hdr_r <= {hdr_r[HDR_BITS-2:0], 1'b0};
            bit_r <= bit_r + BIT_ONE;
            if (bit_r + BIT_ONE == TA_FIRST_BIT && !req_r.write) begin
              oe_r <= 1'b0; // RQ8 RQ11
            end
            if (bit_r + BIT_ONE == DATA_FIRST) begin
              state_r <= ST_DATA; // RQ1
              bit_r   <= BIT_ZERO;
              dout_r  <= shift_r[DATA_W-1]; // RQ9
            end else begin
              dout_r <= hdr_r[HDR_BITS-2];
            end
          end
        end
        ST_DATA: begin
          if (rise_en && !req_r.write) begin
            shift_r <= {shift_r[DATA_W-2:0], din_s2_r}; // RQ9 RQ11
          end
          if (fall_en) begin
            if (req_r.write) begin
              shift_r <= {shift_r[DATA_W-2:0], 1'b0};
              dout_r  <= shift_r[DATA_W-2]; // RQ9
            end
            if (bit_r == DATA_FIRST - BIT_ONE) begin
              state_r <= ST_IDLE; // RQ1
              oe_r    <= 1'b0;    // RQ10
              dout_r  <= 1'b0;
            end else begin
              bit_r <= bit_r + BIT_ONE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  // Answer strobe and captured read data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (state_r == ST_DATA && fall_en && bit_r == DATA_FIRST - BIT_ONE) begin
        done_r <= 1'b1;
        if (!req_r.write) begin
          rdata_r <= shift_r; // RQ11
        end
      end
    end
  end

  // Outputs straight from their flops
  assign done              = done_r;
  assign rdata             = rdata_r;
  assign mgmt_data_line_o  = dout_r;
  assign mgmt_data_line_oe = oe_r;

  // Line is released whenever no frame runs
  a_idle_release: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    (state_r == ST_IDLE && !req_valid) |=> !mgmt_data_line_oe)
    else $error("Data line driven while idle");

  // Preamble holds the line high
  a_preamble_ones: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (state_r == ST_PRE) |-> (mgmt_data_line_oe && mgmt_data_line_o))
    else $error("Preamble bit not one");

  // Read releases line in data field
  a_read_release: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
    (state_r == ST_DATA && !req_r.write) |-> !mgmt_data_line_oe)
    else $error("Line driven during read data");

  // Write keeps driving through data field
  a_write_drive: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    (state_r == ST_DATA && req_r.write) |-> mgmt_data_line_oe)
    else $error("Line released during write data");

  // Header begins with a zero start bit
  a_start_bit: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    ($rose(state_r == ST_HDR)) |-> !mgmt_data_line_o)
    else $error("Start pattern first bit wrong");

  // Preamble lasts 32 bits
  a_pre_length: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (state_r == ST_PRE && fall_en) |-> (bit_r < FRAME_BITS))
    else $error("Preamble count overran");

  // Frame finishes with a one-cycle done pulse raised as the state returns to idle
  a_done_idle: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    done |-> (state_r == ST_IDLE) ##1 !done)
    else $error("Done without return to idle");

  // Clock parked low when idle
  a_clk_parked: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    (state_r == ST_IDLE) |=> (state_r != ST_IDLE) || !mgmt_clock_out)
    else $error("Management clock runs while idle");

endmodule

/* File: tb/phy_mgmt_model.sv */
// Transceiver management port model that decodes frames and answers reads
`timescale 1ns/1ns
module phy_mgmt_model (
  // Management pins
  input  wire logic        mdc,
  input  wire logic        line,
  output logic             drv_oe,
  output logic             drv_o,
  // Bench side
  input  wire logic [15:0] rd_val,
  output logic [13:0]      hdr,
  output logic [15:0]      wdat,
  output logic [5:0]       pre_last,
  output logic [1:0]       ta
);
  logic [5:0] k;
  logic [5:0] pre;
  logic       busy;

  initial begin
    {drv_oe, drv_o, busy, k, pre, hdr, wdat, pre_last, ta} = '0;
  end

  // Capture each bit on the rising management clock
  always @(posedge mdc) begin
    if (!busy) begin
      if (line) begin
        pre <= pre + 6'h01;
      end else begin
        busy     <= 1'b1;
        k        <= 6'h01;
        hdr      <= {hdr[12:0], 1'b0};
        pre_last <= pre;
        pre      <= 6'h00;
      end
    end else begin
      if (k < 6'h0e) hdr <= {hdr[12:0], line};
      else if (k < 6'h10) ta <= {ta[0], line};
      else wdat <= {wdat[14:0], line};
      k <= k + 6'h01;
      if (k == 6'h1f) busy <= 1'b0;
    end
  end

  // Drive turnaround zero then read data after each falling clock
  always @(negedge mdc) begin
    drv_oe <= busy && hdr[11:10] == 2'h2 && k >= 6'h0f;
    drv_o  <= (k == 6'h0f) ? 1'b0 : rd_val[6'h1f - k];
  end
endmodule

/* File: tb/phy_mgmt_master_tb.sv */
// Self-checking bench for the management frame master
`timescale 1ns/1ns
module phy_mgmt_master_tb;
  import mgmt_pkg::*;
  logic        sys_clk, rst, req_valid, req_ready, done;
  logic        mdc, d_i, d_o, d_oe, phy_oe, phy_o;
  logic [15:0] rdata, rd_val, wdat;
  logic [13:0] hdr;
  logic [5:0]  pre_last;
  logic [1:0]  ta;
  mgmt_req_t   req;
  int          mismatches, tests_run, cycles;

  // Line level from both drivers, pulled up when released
  assign d_i = d_oe ? d_o : (phy_oe ? phy_o : 1'b1);

  phy_mgmt_master dut (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .rdata(rdata), .mgmt_clock_out(mdc),
    .mgmt_data_line_i(d_i), .mgmt_data_line_o(d_o),
    .mgmt_data_line_oe(d_oe));
  phy_mgmt_model phy (.mdc(mdc), .line(d_i), .drv_oe(phy_oe),
    .drv_o(phy_o), .rd_val(rd_val), .hdr(hdr), .wdat(wdat),
    .pre_last(pre_last), .ta(ta));

  // Clock generation
  always #20 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One frame: issue, wait for done, then judge the wire and answer
  task automatic frame(input logic wr, input logic pr,
                       input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
    int n;
    int len;
    len = pr ? 640 : 320;
    @(negedge sys_clk);
    chk({15'h0, req_ready}, 16'h1);
    req       = mgmt_req_t'({wr, pr, pa, ra, wd});
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 800) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, n >= len - 3 && n <= len + 3}, 16'h1);
    chk({14'h0, d_oe, mdc}, 16'h0);
    chk({10'h0, pre_last}, pr ? 16'h20 : 16'h0);
    chk({2'h0, hdr},
        {2'h0, START_PAT, wr ? OP_WRITE : OP_READ, pa, ra});
    chk({14'h0, ta}, 16'h2);
    if (wr) chk(wdat, wd);
    chk(rdata, rd_val);
  endtask

  task automatic t_write_pre;
    frame(1'b1, 1'b1, 5'h1f, 5'h00, 16'ha5c3);
    $display("write with preamble finished");
  endtask

  task automatic t_read_short;
    rd_val = 16'h8001;
    frame(1'b0, 1'b0, 5'h10, 5'h1f, 16'hffff);
    $display("read without preamble finished");
  endtask

  // Read then write issued in the cycle after done
  task automatic t_back_to_back;
    rd_val = 16'h7ffe;
    frame(1'b0, 1'b1, 5'h01, 5'h15, 16'h0000);
    frame(1'b1, 1'b0, 5'h0a, 5'h0e, 16'h5a3c);
    $display("back to back frames finished");
  endtask

  task automatic conclude;
    $display("%0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // No clash on the line, and no drive while idle
  always @(negedge sys_clk) begin
    if (!rst) chk({14'h0, d_oe & phy_oe, req_ready & d_oe}, 16'h0);
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    sys_clk   = 1'b0;
    rst       = 1'b1;
    req_valid = 1'b0;
    req       = '0;
    rd_val    = 16'h0000;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    t_write_pre();
    t_read_short();
    t_back_to_back();
    conclude();
  end
endmodule
